// [src/uotg_pkg.sv]
package uotg_pkg;

  // Register byte offsets on the AHB register port.
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_MASK   = 12'h018;
  localparam logic [11:0] OFS_PEEK   = 12'h01c;
  localparam logic [11:0] OFS_POP    = 12'h020;
  localparam logic [11:0] OFS_RXSIZE = 12'h024;
  localparam logic [11:0] OFS_NPSIZE = 12'h028;

  // Status bit positions held by this slice.
  localparam int ST_ROLE     = 0;
  localparam int ST_WRONG    = 1;
  localparam int ST_OTG      = 2;
  localparam int ST_SOF      = 3;
  localparam int ST_RXNE     = 4;
  localparam int ST_NPTXE    = 5;
  localparam int ST_CARKIT   = 8;
  localparam int ST_RESTORE  = 16;
  localparam int ST_INCOMPL  = 21;
  localparam int ST_EXT_LO   = 6;

  // Build options of the controller.
  localparam logic OPT_DYNAMIC_FIFO = 1'b1;
  localparam logic OPT_DED_TX_FIFOS = 1'b0;
  localparam logic OPT_ISO_OUT      = 1'b1;
  localparam logic OPT_HIBERNATION  = 1'b0;

  // FIFO depths in 32-bit words.
  localparam logic [15:0] RX_DEPTH_MAX  = 16'h0400;
  localparam logic [15:0] NP_DEPTH_MAX  = 16'h0200;
  localparam logic [15:0] EP0_DEPTH_MAX = 16'h0100;
  localparam logic [15:0] DEPTH_MIN     = 16'h0010;
  localparam logic [15:0] TX_DEPTH_RST  = OPT_DED_TX_FIFOS ? EP0_DEPTH_MAX : NP_DEPTH_MAX;

  localparam logic [31:0] MASK_RST      = 32'h0000_0000;
  localparam logic [31:0] MASK_WRITABLE = 32'hffff_fffe;
  localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

  // Packet status codes, host mode.
  localparam logic [3:0] PKT_H_IN_DATA  = 4'h2;
  localparam logic [3:0] PKT_H_IN_DONE  = 4'h3;
  localparam logic [3:0] PKT_H_TGL_ERR  = 4'h5;
  localparam logic [3:0] PKT_H_HALTED   = 4'h7;
  // Packet status codes, device mode.
  localparam logic [3:0] PKT_D_GOUT_NAK = 4'h1;
  localparam logic [3:0] PKT_D_OUT_DATA = 4'h2;
  localparam logic [3:0] PKT_D_OUT_DONE = 4'h3;
  localparam logic [3:0] PKT_D_SETUP_OK = 4'h4;
  localparam logic [3:0] PKT_D_SETUP_DT = 4'h6;

  localparam logic [1:0] PID_DATA0 = 2'b00;
  localparam logic [1:0] PID_DATA1 = 2'b10;
  localparam logic [1:0] PID_DATA2 = 2'b01;
  localparam logic [1:0] PID_MDATA = 2'b11;

  localparam int RXQ_WIDTH = 32;
  localparam int RXQ_DEPTH = 8;

  typedef struct packed {
    logic [6:0]  reserved;
    logic [3:0]  frame_number_low;
    logic [3:0]  packet_status_code;
    logic [1:0]  data_pid_code;
    logic [10:0] byte_count;
    logic [3:0]  channel_or_endpoint_number;
  } uotg_rxsts_t;

  typedef struct packed {
    logic        sel;
    logic [1:0]  trans;
    logic        write;
    logic [11:0] addr;
  } uotg_ahb_req_t;

  typedef struct packed {
    logic        present_role;
    logic        low_speed;
    logic        sof_event;
    logic        otg_pending;
    logic        wrong_role_access;
    logic        tx_empty_level_select;
    logic        np_tx_half_empty;
    logic        np_tx_empty;
    logic        np_queue_has_space;
    logic        ulpi_carkit_irq;
    logic        i2c_carkit_irq;
  } uotg_core_evt_t;

endpackage : uotg_pkg

// [src/uotg_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module uotg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,   // Bus clock.
  input  wire logic             arst_n,    // Asynchronous reset.
  input  wire logic             in_valid,  // Write side offers a word.
  output logic                  in_ready,  // Space for a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word to store.
  output logic                  out_valid, // Head word present.
  input  wire logic             out_ready, // Reader takes the head.
  output logic      [WIDTH-1:0] out_data   // Head word.
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        full;
    logic                        empty;
  } uotg_fifo_state_t;

  uotg_fifo_state_t s_q, s_d;
  logic             push, pop;

  assign push      = in_valid && !s_q.full;
  assign pop       = out_ready && !s_q.empty;
  assign in_ready  = !s_q.full;
  assign out_valid = !s_q.empty;
  assign out_data  = s_q.mem[s_q.rd];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = AW'(s_q.wr + 1'b1);
    end
    if (pop) begin
      s_d.rd = AW'(s_q.rd + 1'b1);
    end
    if (push && !pop) begin
      s_d.cnt = (AW+1)'(s_q.cnt + 1'b1);
    end else if (pop && !push) begin
      s_d.cnt = (AW+1)'(s_q.cnt - 1'b1);
    end
    s_d.full  = (s_d.cnt == CNT_FULL);
    s_d.empty = (s_d.cnt == '0);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q       <= '0;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : uotg_fifo

module uotg_regs
  import uotg_pkg::*;
(
  input  wire logic           sys_clk,        // 40 MHz bus clock.
  input  wire logic           arst_n,         // Asynchronous reset, active low.
  input  wire uotg_ahb_req_t  ahb_req,        // AHB address-phase control.
  input  wire logic           hready_in,      // AHB bus ready.
  input  wire logic [31:0]    hwdata,         // AHB write data.
  output logic [31:0]         hrdata,         // AHB read data.
  output logic                hready_out,     // Slave ready.
  output logic                hresp,          // Response, always OKAY.
  input  wire uotg_core_evt_t core_evt,       // Core state and events.
  input  wire logic [31:6]    ext_status,     // Upper status bits from the core.
  input  wire logic           rx_entry_valid, // Receive status offered.
  output logic                rx_entry_ready, // Receive status queue has room.
  input  wire uotg_rxsts_t    rx_entry,       // Receive status entry.
  output logic                core_irq,       // Combined interrupt.
  output logic                rxsts_irq       // Popped entry carried an event code.
);

  typedef struct packed {
    logic        ph_valid;
    logic        ph_write;
    logic [11:0] ph_addr;
    logic        sof;
    logic        wrong;
    logic [31:0] mask;
    logic [15:0] rx_depth;
    logic [15:0] tx_depth;
    logic [15:0] tx_start;
    logic [31:0] rdata;
    logic        irq;
    logic        pkt_irq;
  } uotg_regs_state_t;

  uotg_regs_state_t s_q, s_d;
  uotg_rxsts_t      push_entry, head;
  logic             head_valid, pop, addr_phase;
  logic [31:0]      status, mask_eff, head_word, push_word;

  function automatic logic [15:0] fit(input logic [15:0] v, input logic [15:0] hi);
    fit = (v > hi) ? hi : ((v < DEPTH_MIN) ? DEPTH_MIN : v);
  endfunction : fit

  function automatic logic pkt_raises(input logic host, input logic [3:0] code);
    if (host) begin
      pkt_raises = (code == PKT_H_IN_DONE) || (code == PKT_H_TGL_ERR) ||
                   (code == PKT_H_HALTED);
    end else begin
      pkt_raises = (code == PKT_D_GOUT_NAK) || (code == PKT_D_OUT_DONE) ||
                   (code == PKT_D_SETUP_OK);
    end
  endfunction : pkt_raises

  // Frame number only exists for device-mode isochronous OUT support.
  always_comb begin
    push_entry = rx_entry;
    if (core_evt.present_role || !OPT_ISO_OUT) begin
      push_entry.frame_number_low = '0;
    end
    push_entry.reserved = '0;
  end
  assign push_word = push_entry;

  uotg_fifo #(
    .WIDTH (RXQ_WIDTH),
    .DEPTH (RXQ_DEPTH)
  ) u_rxq (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .in_valid  (rx_entry_valid),
    .in_ready  (rx_entry_ready),
    .in_data   (push_word),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head_word)
  );
  assign head = head_word;

  assign addr_phase = ahb_req.sel && ahb_req.trans[1] && hready_in;
  assign pop = addr_phase && !ahb_req.write && (ahb_req.addr == OFS_POP) && head_valid;

  always_comb begin
    status                 = '0;
    status[31:ST_EXT_LO]   = ext_status;
    status[ST_CARKIT]      = core_evt.ulpi_carkit_irq | core_evt.i2c_carkit_irq;
    status[ST_NPTXE]       = !OPT_DED_TX_FIFOS && core_evt.np_queue_has_space &&
                             (core_evt.tx_empty_level_select ? core_evt.np_tx_empty
                                                             : core_evt.np_tx_half_empty);
    status[ST_RXNE]        = head_valid;
    status[ST_SOF]         = s_q.sof;
    status[ST_OTG]         = core_evt.otg_pending;
    status[ST_WRONG]       = s_q.wrong;
    status[ST_ROLE]        = core_evt.present_role;
  end

  // Without hibernation the restore-done mask bit never reaches the interrupt; it still reads back as written.
  always_comb begin
    mask_eff              = s_q.mask;
    mask_eff[ST_RESTORE]  = s_q.mask[ST_RESTORE] & OPT_HIBERNATION;
    mask_eff[ST_ROLE]     = 1'b0;
  end

  always_comb begin
    s_d         = s_q;
    s_d.pkt_irq = 1'b0;

    if (hready_in) begin
      s_d.ph_valid = addr_phase;
      s_d.ph_write = ahb_req.write;
      s_d.ph_addr  = ahb_req.addr;
    end

    // Write data arrives one cycle after its address phase.
    if (s_q.ph_valid && s_q.ph_write) begin
      unique case (s_q.ph_addr)
        OFS_STATUS: begin
          if (hwdata[ST_SOF]) begin
            s_d.sof = 1'b0;
          end
          if (hwdata[ST_WRONG]) begin
            s_d.wrong = 1'b0;
          end
        end
        OFS_MASK: begin
          s_d.mask = hwdata & MASK_WRITABLE;
        end
        OFS_RXSIZE: begin
          if (OPT_DYNAMIC_FIFO) begin
            s_d.rx_depth = fit(hwdata[15:0], RX_DEPTH_MAX);
          end
        end
        OFS_NPSIZE: begin
          if (OPT_DYNAMIC_FIFO) begin
            s_d.tx_depth = fit(hwdata[31:16], TX_DEPTH_RST);
            s_d.tx_start = (hwdata[15:0] > RX_DEPTH_MAX) ? RX_DEPTH_MAX : hwdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware sets take priority over a same-cycle software clear.
    if (core_evt.sof_event && !core_evt.low_speed) begin
      s_d.sof = 1'b1;
    end
    if (core_evt.wrong_role_access) begin
      s_d.wrong = 1'b1;
    end

    if (addr_phase && !ahb_req.write) begin
      unique case (ahb_req.addr)
        OFS_STATUS: s_d.rdata = status;
        OFS_MASK:   s_d.rdata = s_q.mask;
        OFS_PEEK,
        OFS_POP:    s_d.rdata = head_valid ? head_word : '0;
        OFS_RXSIZE: s_d.rdata = {16'h0000, s_q.rx_depth};
        OFS_NPSIZE: s_d.rdata = {s_q.tx_depth, s_q.tx_start};
        default:    s_d.rdata = '0;
      endcase
    end

    if (pop) begin
      s_d.pkt_irq = pkt_raises(core_evt.present_role, head.packet_status_code);
    end

    s_d.irq = |(status & mask_eff);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q.ph_valid <= 1'b0;
      s_q.ph_write <= 1'b0;
      s_q.ph_addr  <= '0;
      s_q.sof      <= 1'b0;
      s_q.wrong    <= 1'b0;
      s_q.mask     <= MASK_RST;
      s_q.rx_depth <= RX_DEPTH_MAX;
      s_q.tx_depth <= TX_DEPTH_RST;
      s_q.tx_start <= RX_DEPTH_MAX;
      s_q.rdata    <= RDATA_RST;
      s_q.irq      <= 1'b0;
      s_q.pkt_irq  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // The slice never inserts wait states and never answers with an error.
  assign hrdata     = s_q.rdata;
  assign hready_out = 1'b1;
  assign hresp      = 1'b0;
  assign core_irq   = s_q.irq;
  assign rxsts_irq  = s_q.pkt_irq;

endmodule : uotg_regs

`default_nettype wire

// [sim/uotg_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module uotg_regs_monitor
  import uotg_pkg::*;
(
  input wire logic          sys_clk,        // Clock.
  input wire logic          arst_n,         // Reset.
  input wire uotg_ahb_req_t ahb_req,        // Address phase.
  input wire logic          hready_in,      // Bus ready.
  input wire logic [31:0]   hwdata,         // Write data.
  input wire logic [31:0]   hrdata,         // Read data.
  input wire logic          hready_out,     // Slave ready.
  input wire logic          hresp,          // Response.
  input wire logic          rx_entry_valid, // Push offer.
  input wire logic          rx_entry_ready, // Push room.
  input wire logic          core_irq,       // Interrupt.
  input wire logic          rxsts_irq       // Pop event.
);
  logic       rd_q;
  logic       pop_q;
  logic       mwr_q;
  logic       mnz_q;
  logic [3:0] cnt_q;
  wire logic  tk = ahb_req.sel & ahb_req.trans[1] & hready_in & !ahb_req.write;
  wire logic  pop = tk & (ahb_req.addr == OFS_POP);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {rd_q, pop_q, mwr_q, mnz_q} <= 4'h0;
      cnt_q <= 4'h0;
    end else begin
      rd_q  <= tk;
      pop_q <= pop;
      mwr_q <= ahb_req.sel & ahb_req.trans[1] & hready_in & ahb_req.write
               & (ahb_req.addr == OFS_MASK);
      if (mwr_q) mnz_q <= |hwdata[31:1];
      cnt_q <= cnt_q + 4'(rx_entry_valid & rx_entry_ready) - 4'(pop & (cnt_q != 4'h0));
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_no_wait_state: assert property (hready_out) else $error("wait state seen");
  chk_okay_resp: assert property (!hresp) else $error("error response seen");
  chk_pop_pulse: assert property (rxsts_irq |=> !rxsts_irq) else $error("long pulse");
  chk_pop_cause: assert property (rxsts_irq |-> pop_q || $past(pop_q) || $past(pop_q, 2))
    else $error("pulse without pop");
  chk_queue_full: assert property (rx_entry_ready == (cnt_q != 4'h8))
    else $error("queue room wrong");
  chk_rdata_hold: assert property ($changed(hrdata) |-> rd_q) else $error("rdata moved");
  chk_irq_mask: assert property (core_irq |-> mnz_q || $past(mnz_q))
    else $error("irq while masked");
  chk_empty_peek: assert property (tk & (ahb_req.addr == OFS_PEEK) & (cnt_q == 4'h0)
    & !rx_entry_valid |=> hrdata == 32'h0) else $error("empty peek nonzero");
endmodule : uotg_regs_monitor
`default_nettype wire

// [sim/uotg_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module uotg_core_model
  import uotg_pkg::*;
(
  input  wire logic  sys_clk, // Clock.
  input  wire logic  arst_n,  // Reset.
  output logic       vld,     // Entry offered.
  input  wire logic  rdy,     // Queue room.
  output uotg_rxsts_t ent     // Entry.
);
  uotg_rxsts_t q[$];
  // An idle entry bus shows the inverse so nothing stale can pass as data.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vld <= 1'b0;
      ent <= '0;
    end else begin
      if (vld && rdy) void'(q.pop_front());
      vld <= q.size() > 0;
      ent <= (q.size() > 0) ? q[0] : ~ent;
    end
  end
endmodule : uotg_core_model
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uotg_pkg::*;
  logic           sys_clk = 0;
  logic           arst_n = 0;
  uotg_ahb_req_t  req = '0;
  logic [31:0]    hwdata = '0;
  uotg_core_evt_t ev = '0;
  logic [31:6]    ext = '0;
  wire logic [31:0] hrdata;
  wire logic      hready_out, hresp, vld, rdy, core_irq, rxsts_irq;
  wire uotg_rxsts_t ent;
  int             errors = 0, tests_run = 0, cyc = 0;
  logic           seen = 0;
  always #12.5 sys_clk = ~sys_clk;
  uotg_regs i_uotg_regs (.sys_clk(sys_clk), .arst_n(arst_n), .ahb_req(req), .hready_in(1'b1),
    .hwdata(hwdata), .hrdata(hrdata), .hready_out(hready_out), .hresp(hresp), .core_evt(ev),
    .ext_status(ext), .rx_entry_valid(vld), .rx_entry_ready(rdy), .rx_entry(ent),
    .core_irq(core_irq), .rxsts_irq(rxsts_irq));
  uotg_core_model i_uotg_core_model (.sys_clk(sys_clk), .arst_n(arst_n), .vld(vld), .rdy(rdy),
    .ent(ent));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rxsts_irq) seen <= 1'b1;
    if (cyc == 4000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    repeat (2) @(posedge sys_clk);
    req <= '{1'b1, 2'b10, 1'b0, a};
    @(posedge sys_clk) req <= '0;
    @(negedge sys_clk) chk(hrdata, e);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk) req <= '{1'b1, 2'b10, 1'b1, a};
    @(posedge sys_clk) req <= '0;
    hwdata <= d;
    @(posedge sys_clk);
  endtask : wr
  task automatic t_regs();
    rd(OFS_MASK, 32'h0);
    rd(OFS_RXSIZE, {16'h0, RX_DEPTH_MAX});
    rd(OFS_NPSIZE, {NP_DEPTH_MAX, RX_DEPTH_MAX});
    wr(OFS_MASK, '1);
    rd(OFS_MASK, 32'hffff_fffe);
    wr(OFS_MASK, 32'h8);
    @(posedge sys_clk) ev.low_speed <= 1'b1;
    ev.sof_event <= 1'b1;
    @(posedge sys_clk) ev.sof_event <= 1'b0;
    rd(OFS_STATUS, 32'h0);
    ev.low_speed <= 1'b0;
    ev.sof_event <= 1'b1;
    @(posedge sys_clk) ev.sof_event <= 1'b0;
    rd(OFS_STATUS, 32'h8);
    chk(core_irq, 1'b1);
    wr(OFS_STATUS, 32'h8);
    rd(OFS_STATUS, 32'h0);
    chk(core_irq, 1'b0);
    ev.present_role <= 1'b1;
    ev.otg_pending <= 1'b1;
    ev.wrong_role_access <= 1'b1;
    @(posedge sys_clk) ev.wrong_role_access <= 1'b0;
    rd(OFS_STATUS, 32'h7);
    ev.otg_pending <= 1'b0;
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h1);
    ev.present_role <= 1'b0;
    wr(OFS_MASK, 32'h0001_0100);
    ext[16] <= 1'b1;
    rd(OFS_STATUS, 32'h0001_0000);
    chk(core_irq, 1'b0);
    ext[16] <= 1'b0;
    ev.i2c_carkit_irq <= 1'b1;
    rd(OFS_STATUS, 32'h0000_0100);
    chk(core_irq, 1'b1);
    ev.i2c_carkit_irq <= 1'b0;
    $display("test registers done");
  endtask : t_regs
  task automatic t_txempty();
    for (int i = 0; i < 8; i++) begin
      ev.tx_empty_level_select <= i[0];
      ev.np_tx_half_empty <= i[1] | i[2];
      ev.np_tx_empty <= i[2];
      ev.np_queue_has_space <= (i != 6);
      rd(OFS_STATUS, {26'h0, (i != 6) & (i[0] ? i[2] : (i[1] | i[2])), 5'h0});
    end
    ev <= '0;
    $display("test tx empty done");
  endtask : t_txempty
  task automatic t_queue(input logic host, input logic [35:0] codes);
    uotg_rxsts_t e[9];
    logic [3:0]  c;
    ev.present_role <= host;
    for (int i = 0; i < 9; i++) begin
      c = codes[(i % 9) * 4 +: 4];
      e[i] = '{7'h0, host ? 4'h0 : 4'(i), c, 2'(i), 11'(i * 3 + 1), 4'(i)};
      i_uotg_core_model.q.push_back(host ? {e[i][31:25], 4'hf, e[i][20:0]} : e[i]);
    end
    repeat (14) @(posedge sys_clk);
    chk(rdy, 1'b0);
    rd(OFS_STATUS, {27'h0, 1'b1, 3'h0, host});
    for (int i = 0; i < 9; i++) begin
      c = e[i].packet_status_code;
      rd(OFS_PEEK, e[i]);
      seen = 1'b0;
      rd(OFS_POP, e[i]);
      repeat (3) @(posedge sys_clk);
      chk(seen, host ? (c inside {4'h3, 4'h5, 4'h7}) : (c inside {4'h1, 4'h3, 4'h4}));
    end
    rd(OFS_STATUS, {31'h0, host});
    $display("test queue done");
  endtask : t_queue
  task automatic t_size();
    wr(OFS_RXSIZE, 32'h20);
    rd(OFS_RXSIZE, 32'h20);
    wr(OFS_RXSIZE, 32'hffff_8000);
    rd(OFS_RXSIZE, {16'h0, RX_DEPTH_MAX});
    wr(OFS_RXSIZE, 32'h4);
    rd(OFS_RXSIZE, 32'h10);
    wr(OFS_NPSIZE, 32'h0100_0300);
    rd(OFS_NPSIZE, 32'h0100_0300);
    wr(OFS_NPSIZE, '1);
    rd(OFS_NPSIZE, {NP_DEPTH_MAX, RX_DEPTH_MAX});
    rd(12'h0f0, 32'h0);
    $display("test sizes done");
  endtask : t_size
  task automatic results();
    $display("counts: errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_txempty();
    t_queue(1'b1, 36'h275327532);
    t_queue(1'b0, 36'h164321643);
    t_size();
    results();
  end
endmodule : tb
bind uotg_regs uotg_regs_monitor i_uotg_regs_monitor (.sys_clk(sys_clk), .arst_n(arst_n),
  .ahb_req(ahb_req), .hready_in(hready_in), .hwdata(hwdata), .hrdata(hrdata),
  .hready_out(hready_out), .hresp(hresp), .rx_entry_valid(rx_entry_valid),
  .rx_entry_ready(rx_entry_ready), .core_irq(core_irq), .rxsts_irq(rxsts_irq));
`default_nettype wire
